// ### poh_top.sv
/*
  pixel output port and line sync input edge logic: control registers on
  ref_clk, sampling and output stream on the sample clock, a fifo between.
  assumes: colour words come from converter logic on sample_clk; hsync_in
  is an asynchronous pin; register writes are at least 8 ref_clk apart.
*/
// Functional notes
// - eight bit channel words, msb on bit 7
// - fixed latency from sampling instant to outputs until capture_hold stalls the fifo
// - phase moves data, clock, sync together
// - pixel clock follows sampling clock; downstream captures
// - sync input sense from register 0x0e bit 6
// - only leading sync edge acts, trailing ignored
// - bit 0 falling edge, bit 1 rising
// - leading edge is line and clock reference
// - sync output regenerated, programmable polarity and width
`timescale 1ns/1ps
`include "poh_cfg.svh"

module poh_top (
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  input  wire logic               sample_clk,
  input  wire logic               reg_wr,
  input  wire poh_pkg::poh_reg_t  reg_addr,
  input  wire poh_pkg::poh_reg_t  reg_wdata,
  output poh_pkg::poh_reg_t       reg_rdata,
  input  wire logic               hsync_in,
  input  wire poh_pkg::poh_chan_t red_in,
  input  wire poh_pkg::poh_chan_t green_in,
  input  wire poh_pkg::poh_chan_t blue_in,
  output logic                    sample_ready,
  input  wire logic               capture_hold,
  output poh_pkg::poh_chan_t      red_out,
  output poh_pkg::poh_chan_t      green_out,
  output poh_pkg::poh_chan_t      blue_out,
  output logic                    output_pixel_clock,
  output logic                    line_sync_out
);
  import poh_pkg::*;

  localparam int FW = 3*`POH_CHAN_W + 1;   // marker bit plus three channels
  localparam int CW = `POH_CHAN_W;

  // toggle detect, used for both crossings
  function automatic logic edge_of(input logic now_v, input logic old_v);
    edge_of = now_v ^ old_v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ref_clk domain: registers
  poh_reg_t sync_ctrl, next_sync_ctrl;   // sync polarity bits
  poh_cnt_t phase, next_phase;           // sampling slot in the period
  poh_reg_t hs_width, next_hs_width;     // sync output width, pixels
  logic     cfg_tgl, next_cfg_tgl;       // flips on each config write
  logic     line_seen, next_line_seen;   // sticky leading edge flag
  poh_reg_t next_reg_rdata;
  poh_reg_t status;
  logic     lt1, lt2, lt_prev;           // line toggle synchroniser
  logic     rd1, rd2;                    // fifo room synchroniser
  logic     line_evt;
  logic     l_line_tgl;                  // link side line toggle

  // write decode, sticky flag and read mux
  always_comb begin
    line_evt       = edge_of(lt2, lt_prev);
    next_sync_ctrl = sync_ctrl;
    next_phase     = phase;
    next_hs_width  = hs_width;
    next_cfg_tgl   = cfg_tgl;
    next_line_seen = line_seen;
    if (reg_wr) begin
      case (reg_addr)
        `POH_ADDR_SYNC_CTRL: begin
          next_sync_ctrl = reg_wdata;
          next_cfg_tgl   = !cfg_tgl;
        end
        `POH_ADDR_PHASE: begin
          next_phase   = reg_wdata[`POH_CNT_W-1:0];
          next_cfg_tgl = !cfg_tgl;
        end
        `POH_ADDR_HS_WIDTH: begin
          next_hs_width = reg_wdata;
          next_cfg_tgl  = !cfg_tgl;
        end
        `POH_ADDR_STATUS: begin
          // write one clears the line flag
          if (reg_wdata[`POH_BIT_ST_LINE]) begin
            next_line_seen = 1'b0;
          end
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
    // a new edge beats a clear in the same cycle
    if (line_evt) begin
      next_line_seen = 1'b1;
    end
    status                   = '0;
    status[`POH_BIT_ST_LINE] = line_seen;
    status[`POH_BIT_ST_FULL] = !rd2;
    case (reg_addr)
      `POH_ADDR_SYNC_CTRL: next_reg_rdata = sync_ctrl;
      `POH_ADDR_PHASE:     next_reg_rdata = poh_reg_t'(phase);
      `POH_ADDR_HS_WIDTH:  next_reg_rdata = hs_width;
      `POH_ADDR_STATUS:    next_reg_rdata = status;
      default:             next_reg_rdata = '0;
    endcase
  end

  // register ref_clk state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_ctrl <= `POH_RST_SYNC_CTRL;
      phase     <= `POH_RST_PHASE;
      hs_width  <= `POH_RST_HS_WIDTH;
      cfg_tgl   <= 1'b0;
      line_seen <= 1'b0;
      reg_rdata <= '0;
      lt1       <= 1'b0;
      lt2       <= 1'b0;
      lt_prev   <= 1'b0;
      rd1       <= 1'b1;
      rd2       <= 1'b1;
    end else begin
      sync_ctrl <= next_sync_ctrl;
      phase     <= next_phase;
      hs_width  <= next_hs_width;
      cfg_tgl   <= next_cfg_tgl;
      line_seen <= next_line_seen;
      reg_rdata <= next_reg_rdata;
      lt1       <= l_line_tgl;
      lt2       <= lt1;
      lt_prev   <= lt2;
      rd1       <= sample_ready;
      rd2       <= rd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample_clk domain: reset release
  logic rs1, lrst_n;
  always_ff @(posedge sample_clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1    <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      rs1    <= 1'b1;
      lrst_n <= rs1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample_clk domain: sync edge, sampling slot, output stage
  logic              hs1, hs2, hs_prev;       // pin synchroniser and history
  logic              ct1, ct2, ct_prev;       // config toggle synchroniser
  logic              l_in_pol, next_l_in_pol; // leading edge sense
  logic              l_out_pol, next_l_out_pol;
  poh_cnt_t          l_phase, next_l_phase;
  poh_reg_t          l_width, next_l_width;
  poh_cnt_t          cnt, next_cnt;           // slot counter, restarted per line
  logic              pend, next_pend;         // first pixel of line due
  logic              next_l_line_tgl;
  logic [`POH_OUT_LAT-1:0] dly, next_dly;     // strobe delay line
  poh_cnt_t          ocnt, next_ocnt;         // output clock slot
  poh_hs_e           hs_state, next_hs_state;
  poh_reg_t          hs_left, next_hs_left;   // pixels of sync left
  poh_chan_t         next_red, next_green, next_blue;
  logic              next_opc, next_hso;
  logic              lead, cfg_load, strobe, out_strobe, pop;
  logic [FW-1:0]     f_in, f_out;
  logic              f_out_valid, f_out_ready;

  always_comb begin
    // leading edge only; trailing edge produces nothing
    lead = l_in_pol ? (hs2 && !hs_prev)
                    : (!hs2 && hs_prev);
    cfg_load        = edge_of(ct2, ct_prev);
    next_l_in_pol   = cfg_load ? sync_ctrl[`POH_BIT_HS_IN_POL] : l_in_pol;
    next_l_out_pol  = cfg_load ? sync_ctrl[`POH_BIT_HS_OUT_POL] : l_out_pol;
    next_l_phase    = cfg_load ? phase : l_phase;
    next_l_width    = cfg_load ? hs_width : l_width;
    // the edge restarts the pixel period: line and clock reference
    if (lead) begin
      next_cnt = '0;
    end else if (cnt == `POH_CNT_LAST) begin
      next_cnt = '0;
    end else begin
      next_cnt = cnt + 1'b1;
    end
    // phase picks the sampling slot; all outputs follow this strobe
    strobe          = (cnt == l_phase);
    next_pend       = lead ? 1'b1 : (strobe ? 1'b0 : pend);
    next_l_line_tgl = lead ? !l_line_tgl : l_line_tgl;
    f_in            = {pend && strobe, red_in, green_in, blue_in};
    // fixed delay from sampling strobe to output strobe
    next_dly        = {dly[`POH_OUT_LAT-2:0], strobe};
    out_strobe      = dly[`POH_OUT_LAT-1];
    f_out_ready     = out_strobe && !capture_hold;
    pop             = f_out_ready && f_out_valid;
    // output clock rises half a period after the data changes
    next_ocnt       = out_strobe ? '0 : ocnt + 1'b1;
    next_opc        = (next_ocnt >= `POH_CLK_HALF);
    next_red        = pop ? f_out[3*CW-1:2*CW] : red_out;
    next_green      = pop ? f_out[2*CW-1:CW] : green_out;
    next_blue       = pop ? f_out[CW-1:0] : blue_out;
    // regenerated sync rides with its pixel through the fifo
    next_hs_state   = hs_state;
    next_hs_left    = hs_left;
    unique case (hs_state)
      POH_HS_IDLE: begin
        if (pop && f_out[FW-1]) begin
          next_hs_state = POH_HS_ACTIVE;
          next_hs_left  = l_width;
        end
      end
      POH_HS_ACTIVE: begin
        if (pop && f_out[FW-1]) begin
          next_hs_left = l_width;
        end else if (pop && (hs_left <= 8'h01)) begin
          next_hs_state = POH_HS_IDLE;
        end else if (pop) begin
          next_hs_left = hs_left - 1'b1;
        end
      end
    endcase
    next_hso = (next_hs_state == POH_HS_ACTIVE) ? l_out_pol : !l_out_pol;
  end

  // register sample_clk state
  always_ff @(posedge sample_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      hs1                <= 1'b0;
      hs2                <= 1'b0;
      hs_prev            <= 1'b0;
      ct1                <= 1'b0;
      ct2                <= 1'b0;
      ct_prev            <= 1'b0;
      l_in_pol           <= `POH_RST_POL;
      l_out_pol          <= `POH_RST_POL;
      l_phase            <= `POH_RST_PHASE;
      l_width            <= `POH_RST_HS_WIDTH;
      cnt                <= '0;
      pend               <= 1'b0;
      l_line_tgl         <= 1'b0;
      dly                <= '0;
      ocnt               <= '0;
      hs_state           <= POH_HS_IDLE;
      hs_left            <= '0;
      red_out            <= '0;
      green_out          <= '0;
      blue_out           <= '0;
      output_pixel_clock <= 1'b0;
      line_sync_out      <= `POH_RST_HSO;
    end else begin
      hs1                <= hsync_in;
      hs2                <= hs1;
      hs_prev            <= hs2;
      ct1                <= cfg_tgl;
      ct2                <= ct1;
      ct_prev            <= ct2;
      l_in_pol           <= next_l_in_pol;
      l_out_pol          <= next_l_out_pol;
      l_phase            <= next_l_phase;
      l_width            <= next_l_width;
      cnt                <= next_cnt;
      pend               <= next_pend;
      l_line_tgl         <= next_l_line_tgl;
      dly                <= next_dly;
      ocnt               <= next_ocnt;
      hs_state           <= next_hs_state;
      hs_left            <= next_hs_left;
      red_out            <= next_red;
      green_out          <= next_green;
      blue_out           <= next_blue;
      output_pixel_clock <= next_opc;
      line_sync_out      <= next_hso;
    end
  end

  // a stalled drain fills the fifo; sample_ready then drops
  poh_fifo #(
    .WIDTH (FW),
    .DEPTH (`POH_FIFO_DEPTH)
  ) poh_fifo_inst (
    .clk       (sample_clk),
    .rst_n     (lrst_n),
    .in_valid  (strobe),
    .in_data   (f_in),
    .in_ready  (sample_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out),
    .out_ready (f_out_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_msb_lane: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    pop |=> red_out == $past(f_out[3*CW-1:2*CW]) && blue_out == $past(f_out[CW-1:0]))
    else $error("channel word not on its lanes");

  a_fixed_latency: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    $past(lrst_n, `POH_OUT_LAT) |-> out_strobe == $past(strobe, `POH_OUT_LAT))
    else $error("output strobe latency wrong");

  a_phase_slot: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    (cnt == l_phase) |-> ##`POH_OUT_LAT out_strobe)
    else $error("outputs did not follow sampling phase");

  a_clock_after_data: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    !$past(pop) |-> $stable(red_out) && $stable(green_out) && $stable(blue_out))
    else $error("data changed outside an output strobe");

  a_clock_low_edge: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    out_strobe |=> !output_pixel_clock)
    else $error("pixel clock not low after data update");

  a_lead_sense: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    lead |-> (hs2 == l_in_pol) && (hs_prev != l_in_pol))
    else $error("wrong sync edge taken as leading");

  a_trail_ignored: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    (hs2 != hs_prev) && (hs2 != l_in_pol) |-> !lead)
    else $error("trailing sync edge acted on");

  a_pol_loaded: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    cfg_load |=> l_in_pol == $past(sync_ctrl[`POH_BIT_HS_IN_POL]))
    else $error("sync sense not taken from control bit");

  a_line_restart: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    lead |=> cnt == '0 && pend)
    else $error("leading edge did not restart the period");

  a_sync_start: assert property (@(posedge sample_clk) disable iff (!lrst_n)
    pop && f_out[FW-1] |=> line_sync_out == l_out_pol)
    else $error("sync output not asserted with its pixel");

  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
    line_evt |=> line_seen)
    else $error("line flag lost an edge");

  c_lead_edge: cover property (@(posedge sample_clk) disable iff (!lrst_n) lead);
  c_sync_pixel: cover property (@(posedge sample_clk) disable iff (!lrst_n)
    pop && f_out[FW-1]);
  c_fifo_full: cover property (@(posedge sample_clk) disable iff (!lrst_n) !sample_ready);
  c_phase_load: cover property (@(posedge sample_clk) disable iff (!lrst_n)
    cfg_load && (l_phase != phase));
endmodule

// ### poh_cfg.svh
/*
  constants of the pixel output and line sync edge block: register offsets,
  field positions, reset values and link-side timing counts.
  assumes: included by bare name; defines only, no logic.
*/
`ifndef POH_CFG_SVH
`define POH_CFG_SVH

// register offsets
`define POH_ADDR_PHASE      8'h01
`define POH_ADDR_HS_WIDTH   8'h02
`define POH_ADDR_STATUS     8'h03
`define POH_ADDR_SYNC_CTRL  8'h0E

// field positions
`define POH_BIT_HS_IN_POL   6
`define POH_BIT_HS_OUT_POL  3
`define POH_BIT_ST_LINE     0
`define POH_BIT_ST_FULL     1

// reset values
`define POH_RST_SYNC_CTRL   8'h00
`define POH_RST_PHASE       3'h0
`define POH_RST_HS_WIDTH    8'h04
`define POH_RST_POL         1'b0
`define POH_RST_HSO         1'b1

// widths and link timing, in sample clock cycles
`define POH_CHAN_W          8
`define POH_CNT_W           3
`define POH_CNT_LAST        3'h7
`define POH_CLK_HALF        3'h4
`define POH_OUT_LAT         4
`define POH_FIFO_DEPTH      32

`endif

// ### poh_pkg.sv
/*
  types shared by the pixel output and line sync edge block.
  assumes: poh_cfg.svh is reachable by bare name.
*/
`include "poh_cfg.svh"

package poh_pkg;
  typedef logic [`POH_CHAN_W-1:0] poh_chan_t;  // one colour channel word
  typedef logic [7:0]             poh_reg_t;   // control register byte
  typedef logic [`POH_CNT_W-1:0]  poh_cnt_t;   // slot within a pixel period
  typedef enum logic {
    POH_HS_IDLE,
    POH_HS_ACTIVE
  } poh_hs_e;                                  // line sync output state
endpackage

// ### poh_fifo.sv
/*
  single clock fifo with valid/ready on both sides.
  assumes: depth is a power of two; one clock, async active low reset.
*/
`timescale 1ns/1ps

module poh_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];            // storage words
  logic [AW-1:0]    wr_ptr, next_wr_ptr;    // write slot
  logic [AW-1:0]    rd_ptr, next_rd_ptr;    // read slot
  logic [AW:0]      count, next_count;      // words held
  logic             room, next_room;        // registered not-full
  logic             push, pop;

  //////////////////////////////////////////////////////////////////////////
  // next pointers and fill level
  always_comb begin
    push        = in_valid && room;
    pop         = out_ready && (count != '0);
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    case ({push, pop})
      2'b10:   next_count = count + 1'b1;
      2'b01:   next_count = count - 1'b1;
      default: next_count = count;
    endcase
    // ready is a flop so the source sees full without a gate delay
    next_room = (next_count != FULL_CNT);
  end

  // register pointers and level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      room   <= 1'b1;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
      room   <= next_room;
    end
  end

  // storage write, no reset needed
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready  = room;
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
endmodule

// ### poh_sink.sv
/*
  display side capture model: takes one pixel at each output clock rise.
  assumes: runs on sample_clk; the stall request comes from the bench.
*/
`timescale 1ns/1ps

module poh_sink (
  input  wire logic               sample_clk,
  input  wire logic               hold_req,
  input  wire logic               sync_act,
  input  wire poh_pkg::poh_chan_t red_in,
  input  wire poh_pkg::poh_chan_t red_out,
  input  wire poh_pkg::poh_chan_t green_out,
  input  wire poh_pkg::poh_chan_t blue_out,
  input  wire logic               output_pixel_clock,
  input  wire logic               line_sync_out,
  output logic                    capture_hold,
  output poh_pkg::poh_chan_t      cap_red,
  output poh_pkg::poh_chan_t      cap_green,
  output poh_pkg::poh_chan_t      cap_blue,
  output poh_pkg::poh_chan_t      lag,
  output int                      n_sync
);
  import poh_pkg::*;
  logic prev_clk;  // output clock as seen one edge back

  initial begin
    capture_hold = 1'b0;
    prev_clk = 1'b0;
    cap_red = 8'h00;
    cap_green = 8'h00;
    cap_blue = 8'h00;
    lag = 8'h00;
    n_sync = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture on the sampled rise: the data has stood four edges by then
  always @(posedge sample_clk) begin
    capture_hold <= hold_req;
    prev_clk <= output_pixel_clock;
    if (output_pixel_clock === 1'b1 && prev_clk === 1'b0) begin
      cap_red <= red_out;
      cap_green <= green_out;
      cap_blue <= blue_out;
      lag <= red_in - red_out;  // inputs count up, so this is the delay
      if (line_sync_out === sync_act) begin
        n_sync <= n_sync + 1;
      end
    end
  end
endmodule

// ### tb_top.sv
/*
  bench of the pixel output block: register rows, then phase, line sync,
  width, fifo stall and mid-run reset cases, capture model on the output.
  assumes: poh_cfg.svh, poh_pkg, poh_top and poh_sink compiled before.
*/
`timescale 1ns/1ps
`include "poh_cfg.svh"

module tb_top;
  import poh_pkg::*;
  typedef struct {
    logic     wr;
    poh_reg_t addr;
    poh_reg_t wdata;
    poh_reg_t exp;
  } poh_row_s;                     // one register case
  logic      ref_clk = 1'b0;       // control clock
  logic      sample_clk = 1'b0;    // link clock
  logic      reset_n = 1'b0;       // async reset
  logic      reg_wr = 1'b0;        // write strobe
  poh_reg_t  reg_addr = 8'h00;     // register address
  poh_reg_t  reg_wdata = 8'h00;    // write data
  poh_reg_t  reg_rdata;            // read data
  logic      hsync_in = 1'b1;      // line sync pin
  poh_chan_t red_in = 8'h00;       // counts one per link edge
  poh_chan_t green_in = 8'h5A;     // red xor 5a
  poh_chan_t blue_in = 8'hFF;      // red inverted
  logic      sample_ready, capture_hold, output_pixel_clock, line_sync_out;
  poh_chan_t red_out, green_out, blue_out, cap_red, cap_green, cap_blue, lag;
  logic      hold_req = 1'b0;      // stall command to the model
  logic      sync_act = 1'b0;      // active sync level in use
  int        n_sync, errors = 0, n_tests = 0, d0, d5, d1, late, n0, i;
  poh_reg_t  rd;                   // last read value
  poh_row_s  rows [11] = '{
    '{1'b0, `POH_ADDR_SYNC_CTRL, 8'h00, 8'h00}, '{1'b0, `POH_ADDR_PHASE, 8'h00, 8'h00},
    '{1'b0, `POH_ADDR_HS_WIDTH, 8'h00, 8'h04}, '{1'b0, `POH_ADDR_STATUS, 8'h00, 8'h00},
    '{1'b0, 8'h05, 8'h00, 8'h00}, '{1'b1, 8'h05, 8'hFF, 8'h00},
    '{1'b1, `POH_ADDR_PHASE, 8'h03, 8'h03}, '{1'b1, `POH_ADDR_HS_WIDTH, 8'h09, 8'h09},
    '{1'b1, `POH_ADDR_SYNC_CTRL, 8'h48, 8'h48}, '{1'b1, `POH_ADDR_SYNC_CTRL, 8'h00, 8'h00},
    '{1'b1, `POH_ADDR_PHASE, 8'h00, 8'h00}};

  always #5 ref_clk = ~ref_clk;
  always #16 sample_clk = ~sample_clk;  // 32 ns, no fixed phase to ref_clk

  // converter words: a counter, so the capture shows its own latency
  always @(posedge sample_clk) begin
    red_in <= red_in + 8'h01;
    green_in <= (red_in + 8'h01) ^ 8'h5A;
    blue_in <= ~(red_in + 8'h01);
  end

  poh_top poh_top_inst (.ref_clk(ref_clk), .reset_n(reset_n), .sample_clk(sample_clk),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hsync_in(hsync_in), .red_in(red_in), .green_in(green_in), .blue_in(blue_in),
    .sample_ready(sample_ready), .capture_hold(capture_hold), .red_out(red_out),
    .green_out(green_out), .blue_out(blue_out), .output_pixel_clock(output_pixel_clock),
    .line_sync_out(line_sync_out));

  poh_sink poh_sink_inst (.sample_clk(sample_clk), .hold_req(hold_req), .sync_act(sync_act),
    .red_in(red_in), .red_out(red_out), .green_out(green_out), .blue_out(blue_out),
    .output_pixel_clock(output_pixel_clock), .line_sync_out(line_sync_out),
    .capture_hold(capture_hold), .cap_red(cap_red), .cap_green(cap_green),
    .cap_blue(cap_blue), .lag(lag), .n_sync(n_sync));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input poh_reg_t seen, input poh_reg_t exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic sclk(input int n);
    repeat (n) @(posedge sample_clk);
  endtask

  // writes spaced 10 cycles apart, the crossing needs eight
  task automatic reg_write(input poh_reg_t a, input poh_reg_t d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask

  task automatic reg_read(input poh_reg_t a, output poh_reg_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1;
    d = reg_rdata;
  endtask

  task automatic run_row(input poh_row_s r);
    if (r.wr) begin
      reg_write(r.addr, r.wdata);
    end
    reg_read(r.addr, rd);
    check("reg_rdata", rd, r.exp);
  endtask

  // reset for 6 cycles, outputs checked while it is held
  task automatic reset_check;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    check("sync_idle", {7'h00, line_sync_out}, 8'h01);
    check("pix_clk", {7'h00, output_pixel_clock}, 8'h00);
    check("ready", {7'h00, sample_ready}, 8'h01);
    check("red_out", red_out, 8'h00);
    check("rdata", reg_rdata, 8'h00);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    sclk(4);
  endtask

  // counts link edges on which the sync output shows its active level
  task automatic watch(input int n, inout int bad);
    repeat (n) begin
      @(posedge sample_clk);
      #1;
      if (line_sync_out === sync_act) begin
        bad++;
      end
    end
  endtask

  // idle level, leading edge (delay measured), trailing edge (must be quiet)
  task automatic pulse(input logic pol, output int d, output int bad);
    bad = 0;
    d = 0;
    @(posedge sample_clk);
    hsync_in <= ~pol;
    watch(40, bad);
    @(posedge sample_clk);
    hsync_in <= pol;
    while (line_sync_out !== sync_act && d < 40) begin
      @(posedge sample_clk);
      #1;
      d++;
    end
    check("sync_seen", poh_reg_t'(d < 40), 8'h01);
    sclk(48);
    hsync_in <= ~pol;
    watch(40, bad);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_check();
    for (i = 0; i < 11; i++) begin
      run_row(rows[i]);
    end
    // every phase: same latency, channels stay whole
    for (i = 0; i < 8; i++) begin
      reg_write(`POH_ADDR_PHASE, poh_reg_t'(i));
      sclk(40);
      check("lag", lag, poh_reg_t'(`POH_OUT_LAT + 1 + `POH_CLK_HALF));
      check("green", cap_green, cap_red ^ 8'h5A);
      check("blue", cap_blue, ~cap_red);
    end
    // falling edge leads; sync delay moves with the phase
    reg_write(`POH_ADDR_HS_WIDTH, 8'h01);
    reg_write(`POH_ADDR_PHASE, 8'h00);
    pulse(1'b0, d0, late);
    check("late0", poh_reg_t'(late), 8'h00);
    reg_write(`POH_ADDR_PHASE, 8'h05);
    pulse(1'b0, d5, late);
    check("late5", poh_reg_t'(late), 8'h00);
    check("shift", poh_reg_t'(d5 - d0), 8'h05);
    reg_read(`POH_ADDR_STATUS, rd);
    check("line_seen", rd & 8'h01, 8'h01);
    reg_write(`POH_ADDR_STATUS, 8'h01);
    reg_read(`POH_ADDR_STATUS, rd);
    check("cleared", rd, 8'h00);
    // rising edge leads once bit 6 is set
    reg_write(`POH_ADDR_SYNC_CTRL, 8'h40);
    pulse(1'b1, d1, late);
    check("late_r", poh_reg_t'(late), 8'h00);
    check("rise_dly", poh_reg_t'(d1 - d5), 8'h00);
    // active high sync output, width 0 acts as 1
    reg_write(`POH_ADDR_SYNC_CTRL, 8'h08);
    sclk(8);
    sync_act <= 1'b1;
    for (i = 0; i < 4; i += 3) begin
      reg_write(`POH_ADDR_HS_WIDTH, poh_reg_t'(i));
      n0 = n_sync;
      pulse(1'b0, d1, late);
      check("width", poh_reg_t'(n_sync - n0), (i == 0) ? 8'h01 : 8'h03);
      check("late_w", poh_reg_t'(late), 8'h00);
    end
    // downstream stalls until the fifo refuses
    @(posedge sample_clk);
    hold_req <= 1'b1;
    i = 0;
    while (sample_ready !== 1'b0 && i < 600) begin
      @(posedge sample_clk);
      #1;
      i++;
    end
    check("full", {7'h00, sample_ready}, 8'h00);
    reg_read(`POH_ADDR_STATUS, rd);
    check("full_bit", rd & 8'h02, 8'h02);
    @(posedge sample_clk);
    hold_req <= 1'b0;
    i = 0;
    while (sample_ready !== 1'b1 && i < 40) begin
      @(posedge sample_clk);
      #1;
      i++;
    end
    check("room", {7'h00, sample_ready}, 8'h01);
    // mid-run reset brings registers back
    reset_check();
    for (i = 0; i < 3; i++) begin
      run_row(rows[i]);
    end
    test_done();
  end

  // watchdog, about four times the expected run
  initial begin
    #200us;
    errors++;
    test_done();
  end
endmodule
